// ---- common/tbt_pkg.sv ----
/*
  Shared constants and carriers for the timebase timer.
  Assumes one clock, the main oscillator clock, drives every user.
*/
package tbt_pkg;

  ////////////////////////////////////////////////////////////////////
  // Counter and register bus geometry
  localparam int CNT_W = 21;
  localparam int AW    = 4;
  localparam int DW    = 8;

  ////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;

  // Field positions of the control register
  localparam int BIT_OVF = 7;
  localparam int BIT_IEN = 6;
  localparam int BIT_SHI = 2;
  localparam int BIT_SLO = 1;
  localparam int BIT_CLR = 0;

  // Reset values
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic       IEN_RST = 1'h0;
  localparam logic       OVF_RST = 1'h0;

  ////////////////////////////////////////////////////////////////////
  // Counter taps: carry out of bit k repeats every 2^(k+2) osc periods
  localparam int TAP_IV0 = 11;
  localparam int TAP_IV1 = 13;
  localparam int TAP_IV2 = 16;
  localparam int TAP_IV3 = 20;
  localparam int TAP_WT0 = 12;
  localparam int TAP_WT1 = 15;
  localparam int TAP_WT2 = 16;
  localparam int TAP_WDT = 19;
  localparam int TAP_ADC = 6;

  ////////////////////////////////////////////////////////////////////
  // Oscillation wait tracking
  typedef enum logic [1:0] {
    TBT_WAIT_COUNT,
    TBT_WAIT_DONE
  } tbt_wait_t;

  // Register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } tbt_bus_req_t;

endpackage

// ---- rtl/tbt_timer.sv ----
/*
  Timebase timer: 21-bit free-running counter at half the main clock,
  interval flag and interrupt, selectable wait tap, fixed taps for watchdog and A/D.
  Assumes mode, select and run inputs come from logic on mclk.
*/
// The implementer's own choices: strobed register access and the register offsets.
// How it works
// - 21-bit counter increments once every two main clock cycles.
// - Counter holds while the main oscillator is reported stopped.
// - Overflow of the selected tap raises an interval event.
// - Four intervals: 2^13, 2^15, 2^18, 2^22 oscillator periods.
// - Wait time 2^14, 2^17 or 2^18 periods by wait select.
// - Watchdog count clock has a 2^21 period.
// - A/D continuous start clock has a 2^8 period.
// - Writing zero to the clear bit zeroes the counter.
// - Entering main stop or subclock mode clears the counter.
// - Power-on reset clears the counter.
// - Flag sets on each selected interval tap overflow with no clear in that cycle; request while flag and enable.
// - Writing zero clears the flag; writing one leaves it.
// - Clear bit reads one; writing one does nothing.
// - Software clear with overflow in one cycle leaves flag clear.
module tbt_timer (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // Register port
  input  wire tbt_pkg::tbt_bus_req_t      bus_req,
  output logic        [tbt_pkg::DW-1:0]   rdata,
  // Clock controller
  input  wire logic                       main_osc_run,
  input  wire logic                       stop_mode_request,
  input  wire logic                       subclock_switch_bit,
  input  wire logic   [1:0]               osc_wait_select_field,
  output logic                            osc_wait_done,
  // Peripheral clocks and interrupt
  output logic                            wdt_count_tick,
  output logic                            adc_start_tick,
  output logic                            timebase_irq_line
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [tbt_pkg::CNT_W-1:0] cnt_r;
  logic [tbt_pkg::CNT_W-1:0] cnt_nxt;
  logic [tbt_pkg::CNT_W-1:0] carry;
  logic                      half_r;
  logic                      tick;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      sw_clr;
  logic                      mode_clr;
  logic                      any_clr;
  logic                      iv_evt;
  logic                      wt_evt;
  logic                      interval_overflow_flag;
  logic                      interval_irq_enable;
  logic [1:0]                interval_select_field;
  logic [tbt_pkg::DW-1:0]    rdata_r;
  logic                      irq_r;
  logic                      wdt_r;
  logic                      adc_r;
  tbt_pkg::tbt_wait_t        wait_r;

  // Pick the interval tap carry from the select code
  function automatic logic pick_iv(
    input logic [tbt_pkg::CNT_W-1:0] cy,
    input logic [1:0]                s
  );
    case (s)
      2'h0:    pick_iv = cy[tbt_pkg::TAP_IV0];
      2'h1:    pick_iv = cy[tbt_pkg::TAP_IV1];
      2'h2:    pick_iv = cy[tbt_pkg::TAP_IV2];
      default: pick_iv = cy[tbt_pkg::TAP_IV3];
    endcase
  endfunction

  // Pick the oscillation wait tap carry from the wait code
  function automatic logic pick_wt(
    input logic [tbt_pkg::CNT_W-1:0] cy,
    input logic [1:0]                s
  );
    case (s)
      2'h0:    pick_wt = cy[tbt_pkg::TAP_WT0];
      2'h1:    pick_wt = cy[tbt_pkg::TAP_WT1];
      default: pick_wt = cy[tbt_pkg::TAP_WT2];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Half-rate count enable, frozen while stopped, phase restarts on clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
    end else if (any_clr) begin
      half_r <= 1'b0;
    end else if (main_osc_run) begin
      half_r <= ~half_r;
    end
  end

  assign tick = half_r & main_osc_run;

  // Carry chain: carry[k] is high when bits k..0 are all ones
  assign carry[0] = cnt_r[0];
  generate
    for (genvar k = 1; k < tbt_pkg::CNT_W; k++) begin : g_carry
      assign carry[k] = carry[k-1] & cnt_r[k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Bus decode and clear sources
  assign wr_hit   = bus_req.wr & (bus_req.addr == tbt_pkg::ADDR_CTRL);
  assign rd_hit   = bus_req.rd & (bus_req.addr == tbt_pkg::ADDR_CTRL);
  assign sw_clr   = wr_hit & ~bus_req.wdata[tbt_pkg::BIT_CLR];
  assign mode_clr = stop_mode_request | ~subclock_switch_bit;
  assign any_clr  = sw_clr | mode_clr;

  // Tap overflow events on a counting edge
  assign iv_evt = tick & pick_iv(carry, interval_select_field);
  assign wt_evt = tick & pick_wt(carry, osc_wait_select_field);

  ////////////////////////////////////////////////////////////////////
  // Counter next value: clear beats count, hold when stopped
  always_comb begin
    if (any_clr) begin
      cnt_nxt = '0;
    end else if (tick) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // Counter register, zero after power-on reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enable and select fields
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interval_irq_enable   <= tbt_pkg::IEN_RST;
      interval_select_field <= tbt_pkg::SEL_RST;
    end else if (wr_hit) begin
      interval_irq_enable   <= bus_req.wdata[tbt_pkg::BIT_IEN];
      interval_select_field <= bus_req.wdata[tbt_pkg::BIT_SHI:tbt_pkg::BIT_SLO];
    end
  end

  // Overflow flag: set wins over write-zero, suppressed by clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interval_overflow_flag <= tbt_pkg::OVF_RST;
    end else if (iv_evt && !any_clr) begin
      interval_overflow_flag <= 1'b1;
    end else if (wr_hit && !bus_req.wdata[tbt_pkg::BIT_OVF]) begin
      interval_overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt request level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= interval_overflow_flag & interval_irq_enable;
    end
  end

  // Watchdog and A/D tap pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdt_r <= 1'b0;
      adc_r <= 1'b0;
    end else begin
      wdt_r <= tick & carry[tbt_pkg::TAP_WDT] & ~any_clr;
      adc_r <= tick & carry[tbt_pkg::TAP_ADC] & ~any_clr;
    end
  end

  // Oscillation wait: restarts on every clear, ends at tap overflow
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_r <= tbt_pkg::TBT_WAIT_COUNT;
    end else begin
      case (wait_r)
        tbt_pkg::TBT_WAIT_COUNT: begin
          if (wt_evt && !any_clr) begin
            wait_r <= tbt_pkg::TBT_WAIT_DONE;
          end
        end
        tbt_pkg::TBT_WAIT_DONE: begin
          if (any_clr) begin
            wait_r <= tbt_pkg::TBT_WAIT_COUNT;
          end
        end
        default: wait_r <= tbt_pkg::TBT_WAIT_COUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (rd_hit) begin
      rdata_r <= {interval_overflow_flag, interval_irq_enable, 3'h0,
                  interval_select_field, 1'b1};
    end else begin
      rdata_r <= '0;
    end
  end

  // Outputs straight from flip-flops, except wait done, decoded from the wait state
  assign rdata             = rdata_r;
  assign timebase_irq_line = irq_r;
  assign wdt_count_tick    = wdt_r;
  assign adc_start_tick    = adc_r;
  assign osc_wait_done     = (wait_r == tbt_pkg::TBT_WAIT_DONE);

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_write_clr;
    wr_hit && !bus_req.wdata[tbt_pkg::BIT_CLR];
  endsequence

  sequence s_zeroed;
    cnt_r == '0;
  endsequence

  sequence s_tap_hit;
    iv_evt && !any_clr;
  endsequence

  a_count_step: assert property (tick && !any_clr |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter did not step on tick");

  a_count_hold: assert property (!main_osc_run && !any_clr |=> $stable(cnt_r))
    else $error("counter moved while oscillator stopped");

  a_sw_clear: assert property (s_write_clr |=> s_zeroed)
    else $error("software clear did not zero counter");

  a_mode_clear: assert property (mode_clr |=> s_zeroed)
    else $error("mode change did not zero counter");

  a_flag_set: assert property (s_tap_hit |=> interval_overflow_flag)
    else $error("overflow flag not set on tap overflow");

  a_clr_blocks: assert property (
    sw_clr && iv_evt && !interval_overflow_flag |=> !interval_overflow_flag)
    else $error("flag set despite coincident clear");

  a_flag_wclear: assert property (
    wr_hit && !bus_req.wdata[tbt_pkg::BIT_OVF] && !iv_evt |=> !interval_overflow_flag)
    else $error("writing zero did not clear flag");

  a_irq_follow: assert property (
    interval_overflow_flag && interval_irq_enable |=> timebase_irq_line)
    else $error("request missing with flag and enable set");

  a_clr_read: assert property (rd_hit |=> rdata[tbt_pkg::BIT_CLR])
    else $error("clear bit did not read as one");

  a_adc_gap: assert property (
    adc_start_tick |=> !adc_start_tick[*8])
    else $error("A/D start pulses too close");

  a_iv_short: assert property (
    interval_select_field == 2'h0 && tick && !any_clr && cnt_r == 21'h000fff
    |-> iv_evt)
    else $error("shortest interval tap not at bit 11");

endmodule

// ---- verification/tb_tbt_timer.sv ----
/*
  Self-checking bench for the timebase timer.
  Assumes the clock model drives the mode inputs and the bench the bus.
*/
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_tbt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } tbt_row_t;
  // Write value, then expected read back
  localparam tbt_row_t ROWS [6] = '{'{4'h0, 8'h7f, 8'h47}, '{4'h0, 8'h02, 8'h03},
    '{4'h0, 8'h04, 8'h05}, '{4'h0, 8'h06, 8'h07}, '{4'h0, 8'h38, 8'h01},
    '{4'h1, 8'h46, 8'h00}};

  logic                  mclk = 1'b0;
  logic                  rst;
  logic                  go_stop = 1'b0;
  logic                  go_sub = 1'b0;
  logic                  osc_hold = 1'b0;
  tbt_pkg::tbt_bus_req_t req = '0;
  logic [7:0]            rdata, d;
  logic [1:0]            osc_wait_select_field;
  logic                  main_osc_run, stop_mode_request, subclock_switch_bit;
  logic                  osc_wait_done, wdt_count_tick, adc_start_tick, timebase_irq_line;
  int                    n_mismatch = 0, total_checks = 0, cyc = 0, t, t1, tc, tw, o0;
  int                    off [2];

  tbt_clk_model tbt_clk_model_i (.mclk, .rst, .go_stop, .go_sub, .osc_hold, .wsel_in(2'h0),
    .main_osc_run, .stop_mode_request, .subclock_switch_bit, .osc_wait_select_field);
  tbt_timer tbt_timer_i (.mclk, .rst, .bus_req(req), .rdata, .main_osc_run, .stop_mode_request,
    .subclock_switch_bit, .osc_wait_select_field, .osc_wait_done, .wdt_count_tick,
    .adc_start_tick, .timebase_irq_line);

  // Clock and cycle count with hang limit
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge mclk);
    req.addr  <= a;
    req.wdata <= w;
    req.wr    <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the next cycle
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return adc_start_tick;
      1: return timebase_irq_line;
      default: return osc_wait_done;
    endcase
  endfunction

  // Bounded wait for a selected output, time kept in t
  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (pick(s) !== 1'b1 && n < 40000);
    t = cyc;
  endtask

  initial begin
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0);
    `CHK("ctrl_reset", 8'h01, d)
    @(posedge mclk);
    #1 `CHK("rdata_idle", 8'h00, rdata)
    // Table of register accesses
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].w);
      rd(ROWS[i].a);
      `CHK("ctrl_rd", ROWS[i].e, d)
    end
    // A/D tick period, then stretched by a halted oscillator
    wr(4'h0, 8'h00);
    wt(0);
    t1 = t;
    wt(0);
    `CHK("adc_period", 256, t - t1)
    t1 = t;
    @(posedge mclk);
    osc_hold <= 1'b1;
    repeat (100) @(posedge mclk);
    osc_hold <= 1'b0;
    wt(0);
    `CHK("adc_held", 356, t - t1)
    // Shortest interval, flag clear and wait done
    wr(4'h0, 8'h40);
    tc = cyc;
    wt(1);
    t1 = t;
    o0 = t1 - tc;
    `CHK("wait_early", 1'b0, osc_wait_done)
    wr(4'h0, 8'h41);
    @(posedge mclk);
    #1 `CHK("irq_clr", 1'b0, timebase_irq_line)
    wt(2);
    tw = t;
    wt(1);
    `CHK("iv0_period", 8192, t - t1)
    `CHK("wait_14", 1, t - tw)
    // Second interval, same latency from the clear
    wr(4'h0, 8'h42);
    tc = cyc;
    wt(1);
    `CHK("iv1_first", 24576, t - tc - o0)
    // Mask keeps flag, unmask raises request at once
    wr(4'h0, 8'h83);
    rd(4'h0);
    `CHK("ctrl_masked", 8'h83, d)
    `CHK("irq_masked", 1'b0, timebase_irq_line)
    wr(4'h0, 8'hc3);
    @(posedge mclk);
    #1 `CHK("irq_unmask", 1'b1, timebase_irq_line)
    `CHK("wait_set", 1'b1, osc_wait_done)
    // Main stop then subclock clear the counter
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      go_stop <= (m == 0);
      go_sub  <= (m == 1);
      repeat (20) @(posedge mclk);
      go_stop <= 1'b0;
      go_sub  <= 1'b0;
      tc = cyc;
      #1 `CHK("wait_clr", 1'b0, osc_wait_done)
      wt(0);
      off[m] = t - tc;
      `CHK("mode_clr", 1'b1, off[m] >= 256 && off[m] <= 264)
    end
    `CHK("mode_same", off[0], off[1])
    stop_test();
  end
endmodule

// ---- verification/tbt_clk_model.sv ----
/*
  Clock controller model for the timebase timer: stop and subclock
  modes, oscillator gating and wait select.
  Assumes bench requests change right after a rising mclk edge.
*/
module tbt_clk_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Bench requests
  input  wire logic       go_stop,
  input  wire logic       go_sub,
  input  wire logic       osc_hold,
  input  wire logic [1:0] wsel_in,
  // Toward the timer
  output logic            main_osc_run,
  output logic            stop_mode_request,
  output logic            subclock_switch_bit,
  output logic [1:0]      osc_wait_select_field
);
  timeunit 1ns;
  timeprecision 1ns;

  // Oscillator halts in stop and subclock modes or when held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      main_osc_run          <= 1'b1;
      stop_mode_request     <= 1'b0;
      subclock_switch_bit   <= 1'b1;
      osc_wait_select_field <= 2'h0;
    end else begin
      stop_mode_request     <= go_stop;
      subclock_switch_bit   <= !go_sub;
      main_osc_run          <= !(go_stop || go_sub || osc_hold);
      osc_wait_select_field <= wsel_in;
    end
  end
endmodule
